// ---- tpg_consts.svh ----
/*
 * Constants of the CSI-2 test pattern generator: register addresses,
 * indirect indices, field positions, reset values, bar bytes, packet
 * codes and timing figures.
 * Assumes inclusion by bare name from the generator files.
 */
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH

// ------------------------------------------------------------
// Direct register addresses and page
// ------------------------------------------------------------
`define TPG_ADDR_PAGE 8'hB0
`define TPG_ADDR_INDEX 8'hB1
`define TPG_ADDR_DATA 8'hB2
`define TPG_PAGE_GEN 8'h00

// ------------------------------------------------------------
// Indirect indices on the generator page
// ------------------------------------------------------------
`define TPG_IDX_CONTROL 4'h1
`define TPG_IDX_CONFIG 4'h2
`define TPG_IDX_DTVC 4'h3
`define TPG_IDX_LINE_HI 4'h4
`define TPG_IDX_LINE_LO 4'h5
`define TPG_IDX_BAR_HI 4'h6
`define TPG_IDX_BAR_LO 4'h7
`define TPG_IDX_ACT_HI 4'h8
`define TPG_IDX_ACT_LO 4'h9
`define TPG_IDX_TOT_HI 4'hA
`define TPG_IDX_TOT_LO 4'hB
`define TPG_IDX_LPD_HI 4'hC
`define TPG_IDX_LPD_LO 4'hD
`define TPG_IDX_VBP 4'hE
`define TPG_IDX_VFP 4'hF
`define TPG_IDX_BLKLEN 8'h10
`define TPG_IDX_FIX_FIRST 8'h11
`define TPG_IDX_FIX_LAST 8'h20
`define TPG_IDX_STATUS 8'h21

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define TPG_CTL_EN_BIT 0
`define TPG_CTL_FIXED_BIT 1
`define TPG_DTVC_VC_LSB 6
`define TPG_RST_BYTE 8'h00

// ------------------------------------------------------------
// Reference bar bytes, packet codes, checks
// ------------------------------------------------------------
`define TPG_BAR0 8'hAA
`define TPG_BAR1 8'h33
`define TPG_BAR2 8'hF0
`define TPG_BAR3 8'h7F
`define TPG_BAR4 8'h55
`define TPG_BAR5 8'hCC
`define TPG_BAR6 8'h0F
`define TPG_BAR7 8'h80
`define TPG_DT_FS 6'h00
`define TPG_DT_FE 6'h01
`define TPG_ECC_M0 24'hF12CB7
`define TPG_ECC_M1 24'hF2555B
`define TPG_ECC_M2 24'h749A6D
`define TPG_ECC_M3 24'hB8E38E
`define TPG_ECC_M4 24'hDF03F0
`define TPG_ECC_M5 24'hEFFC00
`define TPG_CRC_POLY 16'h8408
`define TPG_CRC_INIT 16'hFFFF

// ------------------------------------------------------------
// Timing: clock period and line period unit, in ns
// ------------------------------------------------------------
`define TPG_CLK_NS 20'd4
`define TPG_LINE_UNIT_NS 20'd10

`endif

// ---- tpg_pkg.sv ----
/*
 * Types of the CSI-2 test pattern generator.
 * Assumes nothing of its surroundings.
 */
package tpg_pkg;
   // Sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_PICK, ST_HDR, ST_PAY, ST_CRC, ST_WAIT} tpg_state_e;
   // One byte beat towards the transmitter
   typedef struct packed
   {
      logic sop;
      logic eop;
      logic [7:0] data;
   } tpg_beat_s;
endpackage

// ---- tpg_mem_if.sv ----
/*
 * Link between the generator and its fixed-colour byte store.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface tpg_mem_if;
   logic wr_en; // Host write strobe
   logic [3:0] wr_addr; // Byte position written
   logic [7:0] wr_data; // Byte written
   logic [3:0] gen_addr; // Position the generator wants next
   logic [7:0] gen_data; // Registered byte for the generator
   logic [3:0] host_addr; // Position software reads back
   logic [7:0] host_data; // Registered byte for software
   modport ctl (output wr_en, wr_addr, wr_data, gen_addr, host_addr, input gen_data, host_data);
   modport mem (input wr_en, wr_addr, wr_data, gen_addr, host_addr, output gen_data, host_data);
endinterface
`default_nettype wire

// ---- tpg_fixmem.sv ----
/*
 * Sixteen byte store for the fixed-colour block, one write port and two
 * registered read ports.
 * Assumes a synchronous active-low reset on the common clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"
module tpg_fixmem
(
   input wire logic clk,
   input wire logic rst_n,
   tpg_mem_if.mem mp
);
   logic [7:0] mem_r [0:15]; // Block byte values

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // Write port, cleared on reset
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 16; i++)
         begin
            mem_r[i] <= `TPG_RST_BYTE;
         end
      end
      else if (mp.wr_en)
      begin
         mem_r[mp.wr_addr] <= mp.wr_data;
      end
   end

   // ------------------------------------------------------------
   // Registered reads
   // ------------------------------------------------------------
   // Both read ports answer one cycle after the address
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mp.gen_data <= `TPG_RST_BYTE;
         mp.host_data <= `TPG_RST_BYTE;
      end
      else
      begin
         mp.gen_data <= mem_r[mp.gen_addr];
         mp.host_data <= mem_r[mp.host_addr];
      end
   end
endmodule
`default_nettype wire

// ---- tpg_pattern_gen.sv ----
/*
 * CSI-2 test pattern generator: indirect register page, frame and line
 * sequencer, colour-bar and fixed-colour byte sources, packet framing
 * with ECC and CRC, and a two-entry output buffer.
 * Assumes the transmit byte clock at 250 MHz, a synchronous host write
 * and read strobe, and a transmitter that may stall with tx_ready.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"

// Notes on behaviour
// - Reference bars AA 33 F0 7F 55 CC 0F 80
// - Last bar fills rest of line
// - One, two, four or eight bars
// - Bar steps at each bar-width boundary
// - Packets carry programmed channel, line packets data type
// - Active lines within total frame lines
// - Line period counted in 10 ns units
// - Front porch blanks before frame end
// - Back porch blanks after frame start
// - Builds whole packets on transmit clock
// - Fixed mode alternates pattern and complement
// - Fixed block of 1 to 16 repeats
// - Sixteen writable fixed block byte registers
// - Settings live on indirect page zero
// - Page, index, data writes reach registers
module tpg_pattern_gen
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_sop,
   output logic tx_eop,
   output logic pattern_active
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Header ECC over data identifier and word count
   function automatic logic [7:0] tpg_ecc(input logic [23:0] h);
      tpg_ecc = {2'b00, ^(h & `TPG_ECC_M5), ^(h & `TPG_ECC_M4), ^(h & `TPG_ECC_M3),
                 ^(h & `TPG_ECC_M2), ^(h & `TPG_ECC_M1), ^(h & `TPG_ECC_M0)};
   endfunction

   // Payload CRC, one byte, low bit first
   function automatic logic [15:0] tpg_crc8(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ `TPG_CRC_POLY) : (r >> 1);
      end
      tpg_crc8 = r;
   endfunction

   // Reference bar byte; the last bar always shows the long-zero byte
   function automatic logic [7:0] tpg_ref(input logic [2:0] idx, input logic [2:0] last);
      logic [7:0] v;
      v = `TPG_BAR7;
      case (idx)
         3'h0: v = `TPG_BAR0;
         3'h1: v = `TPG_BAR1;
         3'h2: v = `TPG_BAR2;
         3'h3: v = `TPG_BAR3;
         3'h4: v = `TPG_BAR4;
         3'h5: v = `TPG_BAR5;
         3'h6: v = `TPG_BAR6;
         default: v = `TPG_BAR7;
      endcase
      tpg_ref = (idx == last) ? `TPG_BAR7 : v;
   endfunction

   // ------------------------------------------------------------
   // Register page
   // ------------------------------------------------------------
   logic [7:0] page_r; // Page select
   logic [7:0] index_r; // Indirect index
   logic [7:0] pg_r [0:15]; // Page registers, entry 0 reserved
   logic [3:0] blklen_r; // Fixed block length minus one
   tpg_mem_if mif ();

   // Address decode of host accesses
   wire ind_wr = reg_wr_en && reg_addr == `TPG_ADDR_DATA && page_r == `TPG_PAGE_GEN;
   wire idx_pg = index_r[7:4] == 4'h0 && index_r[3:0] != 4'h0;
   wire idx_fix = index_r >= `TPG_IDX_FIX_FIRST && index_r <= `TPG_IDX_FIX_LAST;
   wire [7:0] fix_off = index_r - `TPG_IDX_FIX_FIRST;

   // Fields, upper byte at lower index
   wire ctl_en = pg_r[`TPG_IDX_CONTROL][`TPG_CTL_EN_BIT];
   wire ctl_fixed = pg_r[`TPG_IDX_CONTROL][`TPG_CTL_FIXED_BIT];
   wire [1:0] bar_sel = pg_r[`TPG_IDX_CONFIG][1:0];
   wire [7:0] dtvc = pg_r[`TPG_IDX_DTVC];
   wire [15:0] line_len = {pg_r[`TPG_IDX_LINE_HI], pg_r[`TPG_IDX_LINE_LO]};
   wire [15:0] bar_w = {pg_r[`TPG_IDX_BAR_HI], pg_r[`TPG_IDX_BAR_LO]};
   wire [15:0] act_lines = {pg_r[`TPG_IDX_ACT_HI], pg_r[`TPG_IDX_ACT_LO]};
   wire [15:0] tot_lines = {pg_r[`TPG_IDX_TOT_HI], pg_r[`TPG_IDX_TOT_LO]};
   wire [15:0] line_pd = {pg_r[`TPG_IDX_LPD_HI], pg_r[`TPG_IDX_LPD_LO]};
   wire [7:0] vbp = pg_r[`TPG_IDX_VBP];
   wire [7:0] vfp = pg_r[`TPG_IDX_VFP];

   // Direct registers and indirect routing, page zero only
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         page_r <= `TPG_RST_BYTE;
         index_r <= `TPG_RST_BYTE;
         blklen_r <= 4'h0;
         for (int i = 0; i < 16; i++)
         begin
            pg_r[i] <= `TPG_RST_BYTE;
         end
      end
      else if (reg_wr_en)
      begin
         if (reg_addr == `TPG_ADDR_PAGE)
            page_r <= reg_wdata;
         if (reg_addr == `TPG_ADDR_INDEX)
            index_r <= reg_wdata;
         if (ind_wr && idx_pg)
            pg_r[index_r[3:0]] <= reg_wdata;
         if (ind_wr && index_r == `TPG_IDX_BLKLEN)
            blklen_r <= reg_wdata[3:0];
      end
   end

   // Fixed block bytes go to the store
   assign mif.wr_en = ind_wr && idx_fix;
   assign mif.wr_addr = fix_off[3:0];
   assign mif.wr_data = reg_wdata;
   assign mif.host_addr = fix_off[3:0];

   tpg_fixmem u_fixmem
   (
      .clk(clk),
      .rst_n(rst_n),
      .mp(mif.mem)
   );

   // ------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------
   tpg_pkg::tpg_state_e st_r, st_nxt; // Sequencer
   logic [1:0] ph_r, ph_nxt; // Slot phase: start, line, end, done
   logic run_r; // Pattern owns the stream
   logic [15:0] slot_r; // Line slot in frame
   logic [19:0] timer_r; // ns into current slot
   logic [31:0] hdr_r; // Packet header bytes
   logic is_long_r; // Header opens a line packet
   logic [1:0] hcnt_r; // Header byte number
   logic [15:0] byte_cnt_r; // Payload byte number
   logic [15:0] bar_cnt_r; // Byte within bar
   logic [2:0] bar_idx_r; // Current bar
   logic [3:0] blk_r; // Byte within fixed block
   logic [3:0] blk_nxt;
   logic [15:0] crc_r; // Running payload CRC
   logic ccnt_r; // CRC byte number
   logic buf_ready; // Buffer takes a byte
   tpg_pkg::tpg_beat_s beat_in; // Byte offered to buffer

   // Slot classification
   wire [19:0] target_ns = 20'(line_pd) * `TPG_LINE_UNIT_NS;
   wire line_done = timer_r >= target_ns;
   wire [16:0] act_end = 17'(vbp) + 17'(act_lines);
   wire [16:0] fe_slot = act_end + 17'(vfp);
   wire slot_active = {1'b0, slot_r} >= 17'(vbp) && {1'b0, slot_r} < act_end;
   wire fe_hit = {1'b0, slot_r} == fe_slot;
   wire [15:0] slot_inc = slot_r + 16'h0001;
   wire slot_wrap = slot_inc >= tot_lines;

   // Packet choice for the current phase
   wire pick_go = (ph_r == 2'h0 && slot_r == 16'h0000) || (ph_r == 2'h1 && slot_active)
                  || (ph_r == 2'h2 && fe_hit);
   wire [5:0] pick_dt = (ph_r == 2'h0) ? `TPG_DT_FS : (ph_r == 2'h2) ? `TPG_DT_FE : dtvc[5:0];
   wire [7:0] pick_di = {dtvc[7:`TPG_DTVC_VC_LSB], pick_dt};
   wire [15:0] pick_wc = (ph_r == 2'h1) ? line_len : 16'h0000;

   // Byte sources
   wire [2:0] bar_last = 3'((4'h1 << bar_sel) - 4'h1);
   wire bar_edge = bar_cnt_r == bar_w - 16'h0001;
   wire [7:0] ref_byte = tpg_ref(bar_idx_r, bar_last);
   wire [7:0] fix_byte = mif.gen_data ^ {8{bar_idx_r[0]}};
   wire [7:0] pat_byte = ctl_fixed ? fix_byte : ref_byte;
   wire byte_last = byte_cnt_r == line_len - 16'h0001;

   // Offered beat and handshake
   wire in_valid = st_r == tpg_pkg::ST_HDR || st_r == tpg_pkg::ST_PAY || st_r == tpg_pkg::ST_CRC;
   wire push_ok = in_valid && buf_ready;
   wire pay_push = push_ok && st_r == tpg_pkg::ST_PAY;
   assign beat_in.sop = st_r == tpg_pkg::ST_HDR && hcnt_r == 2'h0;
   assign beat_in.eop = (st_r == tpg_pkg::ST_HDR && hcnt_r == 2'h3 && !is_long_r)
                        || (st_r == tpg_pkg::ST_CRC && ccnt_r);
   assign beat_in.data = (st_r == tpg_pkg::ST_HDR) ? hdr_r[8*hcnt_r +: 8] :
                         (st_r == tpg_pkg::ST_CRC) ? (ccnt_r ? crc_r[15:8] : crc_r[7:0]) :
                         pat_byte;

   // Fixed block position, fed ahead to the registered store
   assign blk_nxt = (st_r == tpg_pkg::ST_PICK) ? 4'h0 :
                    !pay_push ? blk_r : (blk_r == blklen_r) ? 4'h0 : blk_r + 4'h1;
   assign mif.gen_addr = blk_nxt;

   // Next state
   always_comb
   begin
      st_nxt = st_r;
      ph_nxt = ph_r;
      case (st_r)
         tpg_pkg::ST_IDLE:
            // Start only from a fresh frame
            if (ctl_en)
            begin
               st_nxt = tpg_pkg::ST_PICK;
               ph_nxt = 2'h0;
            end
         tpg_pkg::ST_PICK:
         begin
            // One phase examined per cycle
            ph_nxt = ph_r + 2'h1;
            if (pick_go)
               st_nxt = tpg_pkg::ST_HDR;
            else if (ph_r == 2'h3)
               st_nxt = tpg_pkg::ST_WAIT;
         end
         tpg_pkg::ST_HDR:
            if (push_ok && hcnt_r == 2'h3)
               st_nxt = !is_long_r ? tpg_pkg::ST_PICK :
                        (line_len == 16'h0000) ? tpg_pkg::ST_CRC : tpg_pkg::ST_PAY;
         tpg_pkg::ST_PAY:
            if (push_ok && byte_last)
               st_nxt = tpg_pkg::ST_CRC;
         tpg_pkg::ST_CRC:
            if (push_ok && ccnt_r)
               st_nxt = tpg_pkg::ST_PICK;
         tpg_pkg::ST_WAIT:
            // Slot ends when its period has run out
            if (line_done)
            begin
               ph_nxt = 2'h0;
               st_nxt = (slot_wrap && !ctl_en) ? tpg_pkg::ST_IDLE : tpg_pkg::ST_PICK;
            end
         default:
            st_nxt = tpg_pkg::ST_IDLE;
      endcase
   end

   // State, phase, frame ownership and slot
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_r <= tpg_pkg::ST_IDLE;
         ph_r <= 2'h0;
         run_r <= 1'b0;
         slot_r <= 16'h0000;
      end
      else
      begin
         st_r <= st_nxt;
         ph_r <= ph_nxt;
         if (st_r == tpg_pkg::ST_IDLE)
         begin
            run_r <= ctl_en;
            slot_r <= 16'h0000;
         end
         else if (st_r == tpg_pkg::ST_WAIT && line_done)
         begin
            run_r <= slot_wrap ? ctl_en : run_r;
            slot_r <= slot_wrap ? 16'h0000 : slot_inc;
         end
      end
   end

   // Slot timer in ns, restarted at each slot
   always_ff @(posedge clk)
   begin
      if (!rst_n || st_r == tpg_pkg::ST_IDLE || (st_r == tpg_pkg::ST_WAIT && line_done))
         timer_r <= 20'h00000;
      else if (!line_done)
         timer_r <= timer_r + `TPG_CLK_NS;
   end

   // Packet framing counters and header
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hdr_r <= 32'h00000000;
         is_long_r <= 1'b0;
         hcnt_r <= 2'h0;
         ccnt_r <= 1'b0;
         crc_r <= `TPG_CRC_INIT;
      end
      else if (st_r == tpg_pkg::ST_PICK && pick_go)
      begin
         hdr_r <= {tpg_ecc({pick_wc, pick_di}), pick_wc, pick_di};
         is_long_r <= ph_r == 2'h1;
         hcnt_r <= 2'h0;
         ccnt_r <= 1'b0;
         crc_r <= `TPG_CRC_INIT;
      end
      else if (push_ok)
      begin
         if (st_r == tpg_pkg::ST_HDR)
            hcnt_r <= hcnt_r + 2'h1;
         if (st_r == tpg_pkg::ST_PAY)
            crc_r <= tpg_crc8(crc_r, pat_byte);
         if (st_r == tpg_pkg::ST_CRC)
            ccnt_r <= 1'b1;
      end
   end

   // Line byte, bar and block positions
   always_ff @(posedge clk)
   begin
      if (!rst_n || st_r == tpg_pkg::ST_PICK)
      begin
         byte_cnt_r <= 16'h0000;
         bar_cnt_r <= 16'h0000;
         bar_idx_r <= 3'h0;
      end
      else if (pay_push)
      begin
         byte_cnt_r <= byte_cnt_r + 16'h0001;
         bar_cnt_r <= (bar_edge && bar_idx_r != bar_last) ? 16'h0000 : bar_cnt_r + 16'h0001;
         bar_idx_r <= (bar_edge && bar_idx_r != bar_last) ? bar_idx_r + 3'h1 : bar_idx_r;
      end
   end

   always_ff @(posedge clk)
   begin
      blk_r <= !rst_n ? 4'h0 : blk_nxt;
   end

   // ------------------------------------------------------------
   // Two-entry output buffer
   // ------------------------------------------------------------
   tpg_pkg::tpg_beat_s b0_r, b1_r; // Head and second entry
   logic [1:0] cnt_r; // Entries held
   wire pop = tx_valid && tx_ready;
   assign buf_ready = cnt_r != 2'h2;

   // Shift register fill and drain
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_r <= 2'h0;
         b0_r <= '0;
         b1_r <= '0;
      end
      else
      begin
         if (push_ok && !pop)
         begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'h0)
               b0_r <= beat_in;
            else
               b1_r <= beat_in;
         end
         else if (pop && !push_ok)
         begin
            cnt_r <= cnt_r - 2'h1;
            b0_r <= b1_r;
         end
         else if (pop && push_ok)
            b0_r <= beat_in;
      end
   end

   assign tx_valid = cnt_r != 2'h0;
   assign tx_data = b0_r.data;
   assign tx_sop = b0_r.sop;
   assign tx_eop = b0_r.eop;
   assign pattern_active = run_r;

   // ------------------------------------------------------------
   // Register read back
   // ------------------------------------------------------------
   wire [7:0] status = {6'h00, st_r != tpg_pkg::ST_IDLE, run_r};
   wire [7:0] ind_rd = (page_r != `TPG_PAGE_GEN) ? 8'h00 :
                       idx_pg ? pg_r[index_r[3:0]] :
                       (index_r == `TPG_IDX_BLKLEN) ? {4'h0, blklen_r} :
                       idx_fix ? mif.host_data :
                       (index_r == `TPG_IDX_STATUS) ? status : 8'h00;
   wire [7:0] rd_mux = (reg_addr == `TPG_ADDR_PAGE) ? page_r :
                       (reg_addr == `TPG_ADDR_INDEX) ? index_r :
                       (reg_addr == `TPG_ADDR_DATA) ? ind_rd : 8'h00;

   // Read data held until the next read
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd_en)
         reg_rdata <= rd_mux;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_bar_first;
      pay_push && !ctl_fixed && bar_idx_r == 3'h0 && bar_last != 3'h0 |-> beat_in.data == 8'hAA;
   endproperty
   a_bar_first: assert property (p_bar_first) else $error("first bar byte wrong");

   property p_bar_tail;
      pay_push && !ctl_fixed && bar_idx_r == bar_last |-> beat_in.data == 8'h80;
   endproperty
   a_bar_tail: assert property (p_bar_tail) else $error("last bar byte wrong");

   property p_bar_range;
      st_r == tpg_pkg::ST_PAY |-> bar_idx_r <= bar_last;
   endproperty
   a_bar_range: assert property (p_bar_range) else $error("bar index past count");

   property p_bar_step;
      pay_push && bar_edge && bar_idx_r != bar_last |=> bar_idx_r == $past(bar_idx_r) + 3'h1;
   endproperty
   a_bar_step: assert property (p_bar_step) else $error("bar did not step");

   property p_long_di;
      push_ok && beat_in.sop && is_long_r |-> beat_in.data == dtvc;
   endproperty
   a_long_di: assert property (p_long_di) else $error("line packet identifier wrong");

   property p_blk_wrap;
      pay_push && blk_r == blklen_r |=> blk_r == 4'h0;
   endproperty
   a_blk_wrap: assert property (p_blk_wrap) else $error("fixed block did not wrap");

   property p_ind_write;
      ind_wr && index_r == 8'h03 |=> pg_r[`TPG_IDX_DTVC] == $past(reg_wdata);
   endproperty
   a_ind_write: assert property (p_ind_write) else $error("indirect write lost");

   property p_start_frame;
      $rose(run_r) |-> slot_r == 16'h0000 && st_r == tpg_pkg::ST_PICK && ph_r == 2'h0;
   endproperty
   a_start_frame: assert property (p_start_frame) else $error("start not at frame");

   property p_line_hold;
      st_r == tpg_pkg::ST_WAIT && !line_done |=> st_r == tpg_pkg::ST_WAIT;
   endproperty
   a_line_hold: assert property (p_line_hold) else $error("slot ended early");

   c_frame_start: cover property (push_ok && beat_in.sop && ph_r == 2'h1);
   c_line_end: cover property (push_ok && beat_in.eop && st_r == tpg_pkg::ST_CRC);
   c_buf_full: cover property (cnt_r == 2'h2 ##1 cnt_r == 2'h2);
   c_frame_wrap: cover property (st_r == tpg_pkg::ST_WAIT && line_done && slot_wrap);
endmodule
`default_nettype wire

// ---- tpg_tx_sink.sv ----
/*
 Transmitter stand-in: takes bytes with a random stalling ready.
 Assumes the generator clock and its synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tpg_tx_sink
(
   input wire logic clk,
   input wire logic rst_n,
   output var logic tx_ready
);
   integer seed = 5812; // Fixed seed
   // --------------------
   // Ready: idle in reset, stalls one beat in four
   // --------------------
   always @(posedge clk)
   begin
      tx_ready <= rst_n && ($random(seed) % 4 != 0);
   end
endmodule
`default_nettype wire

// ---- tb_csi2_test_pattern_generator.sv ----
/*
 Bench for the pattern generator: indirect setup, two frames checked.
 Assumes the sink model drives tx_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_csi2_test_pattern_generator;
   logic clk = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0, tx_ready;
   logic tx_valid, tx_sop, tx_eop, pattern_active;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tx_data;
   logic [7:0] q[$]; // Bytes taken by the sink
   logic [7:0] fb[3]; // Random fixed block bytes
   logic [7:0] n_sop = 8'h00, n_eop = 8'h00; // Packet starts and ends taken
   integer seed = 5812; // Fixed seed
   int err_total = 0, total_checks = 0, cyc = 0;
   tpg_pattern_gen u_dut (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tx_sop(tx_sop), .tx_eop(tx_eop),
      .pattern_active(pattern_active));
   tpg_tx_sink u_sink (.clk(clk), .rst_n(rst_n), .tx_ready(tx_ready));
   initial forever #2 clk = ~clk;
   // Collect taken bytes, cut hangs short
   always @(posedge clk)
   begin
      if (tx_valid && tx_ready)
      begin
         q.push_back(tx_data);
         n_sop <= n_sop + 8'(tx_sop);
         n_eop <= n_eop + 8'(tx_eop);
         if (tx_sop) chk("active", 8'h01, 8'(pattern_active));
      end
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         err_total++;
         close_out();
      end
   end
   // Reference bar byte by position, last bar fills the line
   function automatic logic [7:0] bar(int i);
      logic [7:0] t[8] = '{8'hAA, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h0F, 8'h80};
      return t[(i > 7) ? 7 : i];
   endfunction
   // Fixed block byte by position, second bar complemented
   function automatic logic [7:0] fx(int k);
      return fb[k % 3] ^ {8{k >= 12}};
   endfunction
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      total_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wb(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   // Page, index, data, then release
   task automatic wi(logic [7:0] i, logic [7:0] d);
      wb(8'hB0, 8'h00);
      wb(8'hB1, i);
      wb(8'hB2, d);
      @(posedge clk);
      reg_wr_en <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e, string n);
      @(posedge clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      @(negedge clk);
      chk(n, e, reg_rdata);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence: one frame, eight three-byte bars, channel 1
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      wi(8'h02, 8'h03);
      wi(8'h03, 8'h64);
      wi(8'h05, 8'h1B);
      wi(8'h07, 8'h03);
      wi(8'h09, 8'h01);
      wi(8'h0B, 8'h02);
      rd(8'hB2, 8'h02, "tot_lo");
      rd(8'h10, 8'h00, "unmapped");
      wi(8'h01, 8'h01);
      wi(8'h01, 8'h00);
      while (q.size() < 41) @(negedge clk);
      chk("fs_di", 8'h40, q[0]);
      chk("lp_di", 8'h64, q[4]);
      chk("wc_lo", 8'h1B, q[5]);
      for (int k = 0; k < 27; k++) chk("bar", bar(k / 3), q[8 + k]);
      chk("fe_di", 8'h41, q[37]);
      chk("sops", 8'h03, n_sop);
      chk("eops", 8'h03, n_eop);
      $display("frame test done");
      // Fixed colour: random 3-byte block, two bars, timed slots
      for (int k = 0; k < 3; k++)
      begin
         fb[k] = 8'($random(seed));
         wi(8'h11 + 8'(k), fb[k]);
      end
      rd(8'hB2, fb[2], "fix_rd");
      wi(8'h10, 8'h02);
      wi(8'h02, 8'h01);
      wi(8'h07, 8'h0C);
      wi(8'h0D, 8'h32);
      wi(8'h01, 8'h03);
      wi(8'h01, 8'h02);
      while (q.size() < 82) @(negedge clk);
      for (int k = 0; k < 27; k++) chk("fix", fx(k), q[49 + k]);
      chk("fe2_di", 8'h41, q[78]);
      chk("sops", 8'h06, n_sop);
      chk("eops", 8'h06, n_eop);
      repeat (130) @(posedge clk);
      chk("idle", 8'h00, 8'(pattern_active));
      $display("fixed test done");
      close_out();
   end
endmodule
`default_nettype wire
